// ### bench/stos_safety_unit.sv
`timescale 1ns/10ps
module stos_safety_unit (
  // Clock and command: 0 both OFF, 1 both ON, 2 only channel A ON
  input  wire logic       clk_i,
  input  wire logic [1:0] mode_i,
  // Safety channels, high is ON
  output logic            safety_input_a_o,
  output logic            safety_input_b_o
);
  // Mode 2 stands for a broken channel B wire, the only fault the bench asks for
  always_ff @(posedge clk_i) begin
    safety_input_a_o <= mode_i != 2'd0;
    safety_input_b_o <= mode_i == 2'd1;
  end
endmodule

// ### bench/stos_top_props.sv
`timescale 1ns/10ps
module stos_top_props #(
  parameter int unsigned GLITCH = 20
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic       wb_ack_o,
  input wire logic       wb_err_o,
  input wire logic       safety_input_a_i,
  input wire logic       safety_input_b_i,
  input wire logic       run_enable_a_o,
  input wire logic       run_enable_b_o,
  input wire logic       servo_ready_o,
  input wire logic       brake_release_out_o,
  input wire logic       servo_alarm_out_o,
  input wire logic       alarm_code_bit0_o,
  input wire logic       alarm_code_bit1_o,
  input wire logic       alarm_code_bit2_o
);
  logic [31:0] off_a_r;
  logic [31:0] off_b_r;
  logic        take;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

  // Raw OFF run lengths; margin covers sync chain and filter latency
  always_ff @(posedge clk_i) begin
    if (rst_i || safety_input_a_i) off_a_r <= 32'h0;
    else if (off_a_r != 32'hffff_ffff) off_a_r <= off_a_r + 32'h1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || safety_input_b_i) off_b_r <= 32'h0;
    else if (off_b_r != 32'hffff_ffff) off_b_r <= off_b_r + 32'h1;
  end

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  bus_answer_a: assert property (take |=> wb_ack_o ^ wb_err_o)
    else $error("bus request not answered next cycle");
  unmapped_err_a: assert property (take && wb_adr_i != 8'h00 && wb_adr_i != 8'h04 |=> wb_err_o)
    else $error("unmapped access without error");
  cut_chan_a_a: assert property (off_a_r > GLITCH + 6 |-> !run_enable_a_o && !run_enable_b_o)
    else $error("run enable with channel A off");
  cut_chan_b_a: assert property (off_b_r > GLITCH + 6 |-> !run_enable_a_o && !run_enable_b_o)
    else $error("run enable with channel B off");
  ready_off_a: assert property (off_a_r > GLITCH + 6 || off_b_r > GLITCH + 6 |-> !servo_ready_o)
    else $error("servo ready while blocked");
  brake_drop_a: assert property (off_b_r > GLITCH + 8 |-> !brake_release_out_o)
    else $error("brake still released while blocked");
  alarm_quiet_a: assert property (off_b_r > GLITCH + 6 |-> !(servo_alarm_out_o
    || alarm_code_bit0_o || alarm_code_bit1_o || alarm_code_bit2_o))
    else $error("alarm outputs active while blocked");

  cover property (wb_err_o);
  cover property ($fell(run_enable_a_o));
  cover property (servo_alarm_out_o);
endmodule

bind stos_top stos_top_props #(.GLITCH(GLITCH)) stos_top_props_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .safety_input_a_i(safety_input_a_i),
  .safety_input_b_i(safety_input_b_i), .run_enable_a_o(run_enable_a_o),
  .run_enable_b_o(run_enable_b_o), .servo_ready_o(servo_ready_o),
  .brake_release_out_o(brake_release_out_o), .servo_alarm_out_o(servo_alarm_out_o),
  .alarm_code_bit0_o(alarm_code_bit0_o), .alarm_code_bit1_o(alarm_code_bit1_o),
  .alarm_code_bit2_o(alarm_code_bit2_o));

// ### bench/stos_top_test.sv
`timescale 1ns/10ps
module stos_top_test
  import stos_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, d_alm = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hf;
  logic [31:0] wdat = 32'h0, rdat;
  logic [2:0]  d_code = 3'h0;
  logic [1:0]  mode = 2'h0;
  logic        ack, err, sa, sb, ren_a, ren_b, rdy, brk, dyn, servo_alarm_out, c0, c1, c2;
  logic [32:0] exp_d[$], exp_m[$];
  int          error_cnt = 0, tests_run = 0, cyc_cnt = 0;

  always #2 clk_i = ~clk_i;

  stos_safety_unit stos_safety_unit_inst (.clk_i(clk_i), .mode_i(mode),
    .safety_input_a_o(sa), .safety_input_b_o(sb));

  // Short counts keep the run brief: 20-cycle filter, 10-cycle ms, 5 ms mismatch
  stos_top #(.GLITCH(20), .MS_TICK(10), .MISMATCH(5)) stos_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .safety_input_a_i(sa), .safety_input_b_i(sb), .drive_alarm_i(d_alm),
    .drive_alarm_code_i(d_code), .run_enable_a_o(ren_a), .run_enable_b_o(ren_b),
    .servo_ready_o(rdy), .brake_release_out_o(brk), .dyn_brake_o(dyn),
    .servo_alarm_out_o(servo_alarm_out), .alarm_code_bit0_o(c0), .alarm_code_bit1_o(c1),
    .alarm_code_bit2_o(c2));

  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic end_sim();
    if (exp_d.size() != 0) error_cnt++;
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Entered just after a rising edge; notes {err, data} and its mask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [32:0] m, input logic [32:0] e);
    exp_m.push_back(m);
    exp_d.push_back(e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge clk_i);
    end while (!(ack || err));
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 33'h1_0000_0000, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 33'h1_ffff_ffff, {1'b0, e});
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Answer watcher: oldest note against each ack or err
  always @(posedge clk_i) begin
    if (ack || err) begin
      if (exp_d.size() == 0) begin
        error_cnt++;
        $display("mismatch at %0t: seen %h expected %h", $time, {err, rdat}, 33'h0);
      end else chk({err, rdat} & exp_m.pop_front(), exp_d.pop_front());
    end
  end

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt > 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(12));
    wt(4);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(CTRL_OFS, CTRL_RESET);
    rd(STATUS_OFS, 32'h1);
    wb(1'b0, 8'h08, 32'h0, 33'h1_ffff_ffff, 33'h1_0000_0000);
    wb(1'b1, 8'h0c, 32'h3, 33'h1_0000_0000, 33'h1_0000_0000);
    wr(STATUS_OFS, 32'hffff_ffff);
    rd(STATUS_OFS, 32'h1);
    mode <= 2'd1;
    wr(CTRL_OFS, 32'h2);
    wt(10);
    rd(STATUS_OFS, 32'h72);
    wr(CTRL_OFS, 32'h0000_ff07);
    rd(STATUS_OFS, 32'h74);
    mode <= 2'd0;
    wt($urandom_range(20, 1));
    mode <= 2'd1;
    wt(30);
    chk(33'({ren_a, ren_b, brk}), 33'h7);
    // Channel A alone; a long brake delay must not hold the brake released
    mode <= 2'd2;
    wt(32);
    chk(33'({ren_a, ren_b, rdy, brk, dyn}), 33'h1);
    mode <= 2'd1;
    wt(10);
    rd(STATUS_OFS, 32'h31);
    wr(CTRL_OFS, 32'h0000_ff06);
    rd(STATUS_OFS, 32'h72);
    wr(CTRL_OFS, 32'h13);
    rd(STATUS_OFS, 32'h74);
    mode <= 2'd0;
    wt(32);
    mode <= 2'd1;
    wt(10);
    wr(CTRL_OFS, 32'h12);
    wr(CTRL_OFS, 32'h13);
    rd(STATUS_OFS, 32'hf2);
    wr(CTRL_OFS, 32'h03);
    rd(STATUS_OFS, 32'h74);
    d_alm <= 1'b1;
    d_code <= 3'($urandom_range(7, 0));
    wt(2);
    chk(33'({servo_alarm_out, c2, c1, c0, rdy}), 33'({1'b1, d_code, 1'b0}));
    mode <= 2'd2;
    wt(80);
    chk(33'({servo_alarm_out, c2, c1, c0}), 33'h0);
    d_alm <= 1'b0;
    mode <= 2'd1;
    wt(10);
    rd(STATUS_OFS, 32'h39);
    wr(CTRL_OFS, 32'h22);
    wt(2);
    rd(STATUS_OFS, 32'h72);
    rd(CTRL_OFS, 32'h02);
    mode <= 2'd0;
    wt(32);
    chk(33'(dyn), 33'h0);
    wr(CTRL_OFS, 32'h0a);
    mode <= 2'd1;
    wt(10);
    rd(STATUS_OFS, 32'h131);
    wr(CTRL_OFS, 32'h02);
    wt(2);
    wr(CTRL_OFS, 32'h01);
    rd(STATUS_OFS, 32'h32);
    end_sim();
  end
endmodule

// ### verilog/stos_filt_if.sv
`timescale 1ns/10ps
interface stos_filt_if;
  logic raw;
  logic clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// ### verilog/stos_filter.sv
`timescale 1ns/10ps
module stos_filter
  import stos_pkg::*;
#(
  parameter int unsigned GLITCH = GLITCH_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  stos_filt_if.filt f
);
  logic [2:0]  sync_r;
  logic [18:0] cnt_r;
  logic        clean_r;

  // Three flops; a change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], f.raw};
    end
  end

  // ON passes straight; OFF counts only after lasting beyond the glitch time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r   <= 19'h0;
      clean_r <= 1'b0;
    end else if (sync_r[1] && sync_r[2]) begin
      cnt_r   <= 19'h0;
      clean_r <= 1'b1;
    end else if (!sync_r[1] && !sync_r[2]) begin
      if (cnt_r > 19'(GLITCH)) begin
        clean_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r + 19'h1;
      end
    end
  end

  assign f.clean = clean_r;
endmodule

// ### verilog/stos_pkg.sv
package stos_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned GLITCH_US       = 500;
  localparam int unsigned MISMATCH_S      = 10;
  localparam int unsigned OFF_DEADLINE_MS = 20;
  localparam int unsigned GLITCH_CYC      = CLK_HZ / 1_000_000 * GLITCH_US;
  localparam int unsigned MS_CYC          = CLK_HZ / 1000;
  localparam int unsigned MISMATCH_MS     = MISMATCH_S * 1000;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;

  // Control register fields
  localparam int unsigned CTRL_SON_BIT     = 0;
  localparam int unsigned CTRL_MAINPWR_BIT = 1;
  localparam int unsigned CTRL_STOPDB_BIT  = 2;
  localparam int unsigned CTRL_SONALLOC_BIT = 3;
  localparam int unsigned CTRL_UTIL_BIT    = 4;
  localparam int unsigned CTRL_ALMRST_BIT  = 5;
  localparam int unsigned CTRL_BRKDLY_LSB  = 8;
  localparam int unsigned CTRL_BRKDLY_W    = 8;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;

  // Status register fields
  localparam int unsigned ST_BLOCK_BIT  = 0;
  localparam int unsigned ST_IDLE_BIT   = 1;
  localparam int unsigned ST_RUN_BIT    = 2;
  localparam int unsigned ST_TALM_BIT   = 3;
  localparam int unsigned ST_CHA_BIT    = 4;
  localparam int unsigned ST_CHB_BIT    = 5;
  localparam int unsigned ST_RDY_BIT    = 6;
  localparam int unsigned ST_UTILH_BIT  = 7;
  localparam int unsigned ST_CFGERR_BIT = 8;

  typedef enum logic [1:0] {
    STOS_BLOCKED,
    STOS_IDLE,
    STOS_RUN
  } stos_state_t;

endpackage

// ### verilog/stos_top.sv
`timescale 1ns/10ps
module stos_top
  import stos_pkg::*;
#(
  parameter int unsigned GLITCH   = GLITCH_CYC,
  parameter int unsigned MS_TICK  = MS_CYC,
  parameter int unsigned MISMATCH = MISMATCH_MS
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Safety channels, high is ON
  input  wire logic        safety_input_a_i,
  input  wire logic        safety_input_b_i,
  // Alarm sources from the rest of the drive
  input  wire logic        drive_alarm_i,
  input  wire logic [2:0]  drive_alarm_code_i,
  // Drive outputs
  output logic             run_enable_a_o,
  output logic             run_enable_b_o,
  output logic             servo_ready_o,
  output logic             brake_release_out_o,
  output logic             dyn_brake_o,
  output logic             servo_alarm_out_o,
  output logic             alarm_code_bit0_o,
  output logic             alarm_code_bit1_o,
  output logic             alarm_code_bit2_o
);

  stos_filt_if fa ();
  stos_filt_if fb ();
  assign fa.raw = safety_input_a_i;
  assign fb.raw = safety_input_b_i;

  stos_filter #(.GLITCH(GLITCH)) u_fa (.clk_i(clk_i), .rst_i(rst_i), .f(fa));
  stos_filter #(.GLITCH(GLITCH)) u_fb (.clk_i(clk_i), .rst_i(rst_i), .f(fb));

  logic        cha;
  logic        chb;
  assign cha = fa.clean;
  assign chb = fb.clean;

  // Registers
  logic [31:0]              ctrl_r;
  stos_state_t              state_r;
  logic                     talm_r;
  logic                     util_hold_r;
  logic [CTRL_BRKDLY_W-1:0] brk_cnt_r;
  logic                     brake_r;
  logic                     dyn_r;
  logic [17:0]              ms_cnt_r;
  logic                     ms_tick;
  logic [13:0]              mis_cnt_r;
  logic                     ack_r;
  logic                     err_r;
  logic [31:0]              rdat_r;
  logic [31:0]              status_w;

  logic son;
  logic mainpwr;
  logic son_fixed;
  logic util_act;
  logic alm_rst;
  logic any_off;
  logic both_on;
  logic agree;
  logic blocked;
  logic req;

  assign son       = ctrl_r[CTRL_SON_BIT];
  assign mainpwr   = ctrl_r[CTRL_MAINPWR_BIT];
  assign son_fixed = ctrl_r[CTRL_SONALLOC_BIT];
  assign util_act  = ctrl_r[CTRL_UTIL_BIT];
  assign alm_rst   = ctrl_r[CTRL_ALMRST_BIT];
  assign any_off   = !cha || !chb;
  assign both_on   = cha && chb;
  assign agree     = cha == chb;
  assign blocked   = state_r == STOS_BLOCKED;
  assign req       = wb_cyc_i && wb_stb_i && !ack_r && !err_r;

  function automatic logic [31:0] stos_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Only the two mapped words answer with ack; anything else gets err
  function automatic logic stos_adr_hit(input logic [7:0] adr);
    return adr == CTRL_OFS || adr == STATUS_OFS;
  endfunction

  // Status word built from the package field positions
  always_comb begin
    status_w                = 32'h0;
    status_w[ST_BLOCK_BIT]  = blocked;
    status_w[ST_IDLE_BIT]   = state_r == STOS_IDLE;
    status_w[ST_RUN_BIT]    = state_r == STOS_RUN;
    status_w[ST_TALM_BIT]   = talm_r;
    status_w[ST_CHA_BIT]    = cha;
    status_w[ST_CHB_BIT]    = chb;
    status_w[ST_RDY_BIT]    = servo_ready_o;
    status_w[ST_UTILH_BIT]  = util_hold_r;
    status_w[ST_CFGERR_BIT] = blocked && son_fixed;
  end

  // Wishbone: one-cycle answer, ack or err, dropped after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      ack_r <= req && stos_adr_hit(wb_adr_i);
      err_r <= req && !stos_adr_hit(wb_adr_i);
    end
  end

  // Control register; alarm reset bit self-clears after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RESET;
    end else if (req && wb_we_i && wb_adr_i == CTRL_OFS) begin
      ctrl_r <= stos_merge(ctrl_r, wb_dat_i, wb_sel_i);
    end else begin
      ctrl_r[CTRL_ALMRST_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= 32'h0;
    end else if (req && !wb_we_i) begin
      if (wb_adr_i == CTRL_OFS) begin
        rdat_r <= ctrl_r;
      end else if (wb_adr_i == STATUS_OFS) begin
        rdat_r <= status_w;
      end else begin
        rdat_r <= 32'h0;
      end
    end
  end

  assign wb_dat_o = rdat_r;
  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;

  // Millisecond enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ms_cnt_r <= 18'h0;
    end else if (ms_cnt_r == 18'(MS_TICK - 1)) begin
      ms_cnt_r <= 18'h0;
    end else begin
      ms_cnt_r <= ms_cnt_r + 18'h1;
    end
  end
  assign ms_tick = ms_cnt_r == 18'(MS_TICK - 1);

  // Channel mismatch timer; alarm set wins over reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mis_cnt_r <= 14'h0;
    end else if (agree) begin
      mis_cnt_r <= 14'h0;
    end else if (ms_tick && mis_cnt_r < 14'(MISMATCH)) begin
      mis_cnt_r <= mis_cnt_r + 14'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      talm_r <= 1'b0;
    end else if (!agree && mis_cnt_r >= 14'(MISMATCH)) begin
      talm_r <= 1'b1;
    end else if (alm_rst && agree) begin
      talm_r <= 1'b0;
    end
  end

  // Utility interrupted by a block must be cancelled before run returns
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      util_hold_r <= 1'b0;
    end else if (any_off && util_act) begin
      util_hold_r <= 1'b1;
    end else if (!util_act) begin
      util_hold_r <= 1'b0;
    end
  end

  // Supervisor state machine
  // Power-up lands in the block, so nothing runs before both channels read ON
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= STOS_BLOCKED;
    end else begin
      case (state_r)
        STOS_BLOCKED: begin
          // Leaving the block needs servo-on low and the fixed allocation bit clear
          if (both_on && !talm_r && !son && !son_fixed) begin
            state_r <= STOS_IDLE;
          end
        end
        STOS_IDLE: begin
          if (any_off || talm_r) begin
            state_r <= STOS_BLOCKED;
          end else if (son && mainpwr && !util_hold_r) begin
            state_r <= STOS_RUN;
          end
        end
        STOS_RUN: begin
          if (any_off || talm_r) begin
            state_r <= STOS_BLOCKED;
          end else if (!son || !mainpwr) begin
            state_r <= STOS_IDLE;
          end
        end
        default: begin
          state_r <= STOS_BLOCKED;
        end
      endcase
    end
  end

  // Run enables cut combinationally per channel, well inside the 20 ms limit
  assign run_enable_a_o = cha && state_r == STOS_RUN;
  assign run_enable_b_o = chb && state_r == STOS_RUN;

  // Ready only outside the block with main power up and no alarm
  assign servo_ready_o = !blocked && mainpwr && !talm_r && !drive_alarm_i;

  // Brake: normal servo-off uses the delay, the block drops it at once
  // The delay counts in ms ticks and only on an ordinary run to idle step
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brake_r   <= 1'b0;
      brk_cnt_r <= '0;
    end else if (blocked || any_off) begin
      brake_r   <= 1'b0;
      brk_cnt_r <= '0;
    end else if (state_r == STOS_RUN) begin
      brake_r   <= 1'b1;
      brk_cnt_r <= ctrl_r[CTRL_BRKDLY_LSB +: CTRL_BRKDLY_W];
    end else if (brk_cnt_r != '0) begin
      if (ms_tick) begin
        brk_cnt_r <= brk_cnt_r - 1'b1;
      end
    end else begin
      brake_r <= 1'b0;
    end
  end
  assign brake_release_out_o = brake_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dyn_r <= 1'b0;
    end else begin
      dyn_r <= blocked && ctrl_r[CTRL_STOPDB_BIT];
    end
  end
  assign dyn_brake_o = dyn_r;

  // Alarm outputs silent during the block
  assign servo_alarm_out_o = !blocked && (drive_alarm_i || talm_r);
  assign alarm_code_bit0_o = !blocked && drive_alarm_code_i[0];
  assign alarm_code_bit1_o = !blocked && drive_alarm_code_i[1];
  assign alarm_code_bit2_o = !blocked && drive_alarm_code_i[2];

endmodule
